// >>> rtl/dmiu_core.sv
// data move instruction sequencer and datapath
`timescale 1ns/100ps
`include "dmiu_defs.svh"
module dmiu_core
  import dmiu_pkg::*;
(
  input  wire logic        i_core_clk,  // 40 MHz core clock
  input  wire logic        i_rst_b,     // async reset, active low
  input  wire logic        i_start,     // one-cycle issue pulse
  input  wire dmiu_op_t    i_op,        // operation
  input  wire dmiu_reg_t   i_reg,       // register operand kind
  input  wire dmiu_am_t    i_amode,     // immediate-to-memory mode
  input  wire logic [6:0]  i_imm7,      // short immediate
  input  wire logic [15:0] i_imm16,     // extension-word immediate
  input  wire logic [5:0]  i_short_addr,// peripheral short address
  input  wire logic [15:0] i_ea_addr,   // memory address of imm move
  input  wire logic [1:0]  i_ea_cycles, // effective address cycles
  input  wire logic        i_post_ofs,  // increment by offset
  input  wire logic [15:0] i_pointer,   // pointer_two value
  input  wire logic [15:0] i_offset,    // offset register value
  input  wire logic [35:0] i_acc,       // accumulator source
  input  wire logic [15:0] i_src,       // plain register source
  input  wire logic [3:0]  i_prog_wait, // program wait states
  input  wire logic [15:0] i_mem_rdata, // memory read word
  input  wire logic        i_exec_data, // execute_from_data_memory_bit
  output logic             o_busy,      // sequence running
  output logic             o_done,      // one-cycle end pulse
  output logic [1:0]       o_words,     // program words used
  output logic             o_reg_we,    // register write strobe
  output dmiu_reg_t        o_reg_sel,   // register written
  output logic [35:0]      o_reg_wdata, // register write value
  output logic             o_ptr_we,    // pointer write strobe
  output logic [15:0]      o_ptr_wdata, // new pointer value
  output logic             o_dmem_we,   // data memory write
  output logic             o_pmem_we,   // program memory write
  output logic             o_mem_rd,    // memory read strobe
  output logic [15:0]      o_mem_addr,  // memory address
  output logic [15:0]      o_mem_wdata, // memory write word
  output logic             o_limit,     // sticky limit flag
  output logic             o_illegal    // program move refused
);
  // sign extension of a word into accumulator form
  function automatic logic [35:0] acc_load(input logic [15:0] w);
    acc_load = {{4{w[15]}}, w, 16'h0000};
  endfunction : acc_load

  dmiu_state_t st_q, st_d;         // sequencer state
  logic [7:0]  cnt_q, cnt_d;       // cycles remaining
  dmiu_op_t    op_q, op_d;         // latched operation
  dmiu_reg_t   rg_q, rg_d;         // latched register kind
  logic        busy_q, busy_d;
  logic        done_q, done_d;
  logic [1:0]  words_q, words_d;
  logic        rwe_q, rwe_d;
  dmiu_reg_t   rsel_q, rsel_d;
  logic [35:0] rdat_q, rdat_d;
  logic        pwe_q, pwe_d;
  logic [15:0] pdat_q, pdat_d;
  logic        dwe_q, dwe_d;
  logic        pmw_q, pmw_d;
  logic        mrd_q, mrd_d;
  logic [15:0] addr_q, addr_d;
  logic [15:0] wdat_q, wdat_d;
  logic        lim_q, lim_d;
  logic        ill_q, ill_d;
  logic [15:0] imm_q, imm_d;       // latched 16-bit value
  logic [15:0] lim_word;           // limited source word
  logic        lim_hit;            // limiter saturated

  dmiu_limiter u_lim (
    .i_acc     (i_acc),
    .i_word    (i_src),
    .i_sel     (i_reg),
    .o_word    (lim_word),
    .o_limited (lim_hit)
  );

  // sequencer next state and strobes
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    op_d = op_q;
    rg_d = rg_q;
    busy_d = busy_q;
    done_d = 1'b0;
    words_d = words_q;
    rwe_d = 1'b0;
    rsel_d = rsel_q;
    rdat_d = rdat_q;
    pwe_d = 1'b0;
    pdat_d = pdat_q;
    dwe_d = 1'b0;
    pmw_d = 1'b0;
    mrd_d = 1'b0;
    addr_d = addr_q;
    wdat_d = wdat_q;
    lim_d = lim_q;
    ill_d = 1'b0;
    imm_d = imm_q;
    case (st_q)
      DMIU_ST_IDLE: begin
        if (i_start) begin
          op_d = i_op;
          rg_d = i_reg;
          busy_d = 1'b1;
          st_d = DMIU_ST_BUSY;
          case (i_op)
            DMIU_OP_SHORT_IMM: begin
              cnt_d = `DMIU_CYC_SHORT_IMM;
              words_d = `DMIU_WRD_ONE;
              imm_d = {{9{i_imm7[6]}}, i_imm7};
            end
            DMIU_OP_LONG_IMM: begin
              cnt_d = `DMIU_CYC_LONG_IMM;
              words_d = `DMIU_WRD_TWO;
              imm_d = i_imm16;
            end
            DMIU_OP_IMM_MEM: begin
              cnt_d = `DMIU_CYC_IMM_MEM;
              words_d = (i_amode == DMIU_AM_ABSOLUTE) ?
                        `DMIU_WRD_THREE : `DMIU_WRD_TWO;
              addr_d = i_ea_addr;
              wdat_d = i_imm16;
            end
            DMIU_OP_PROG_RD, DMIU_OP_PROG_WR: begin
              if (i_exec_data) begin
                // refused, flagged for one cycle
                busy_d = 1'b0;
                ill_d = 1'b1;
                done_d = 1'b1;
                st_d = DMIU_ST_IDLE;
              end
              cnt_d = `DMIU_CYC_PROG + {4'h0, i_prog_wait};
              words_d = `DMIU_WRD_ONE;
              addr_d = i_pointer;
              wdat_d = lim_word;
              if (lim_hit && !i_exec_data && i_op == DMIU_OP_PROG_WR)
                lim_d = 1'b1;
              // post-increment by one or by the offset
              pdat_d = i_pointer + (i_post_ofs ? i_offset
                                               : 16'h0001);
            end
            DMIU_OP_PER_RD, DMIU_OP_PER_WR: begin
              cnt_d = `DMIU_CYC_PERIPH + {6'h00, i_ea_cycles};
              words_d = `DMIU_WRD_ONE + i_ea_cycles;
              addr_d = {`DMIU_PERIPH_BASE, i_short_addr};
              wdat_d = lim_word;
              if (lim_hit && i_op == DMIU_OP_PER_WR)
                lim_d = 1'b1;
            end
            default: begin
              cnt_d = `DMIU_CYC_PERIPH_IMM;
              words_d = `DMIU_WRD_TWO;
              addr_d = {`DMIU_PERIPH_BASE, i_short_addr};
              wdat_d = i_imm16;
            end
          endcase
        end
      end
      DMIU_ST_BUSY: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h02) begin
          // memory access in the second-to-last cycle
          case (op_q)
            DMIU_OP_IMM_MEM, DMIU_OP_PER_WR, DMIU_OP_PER_IMM:
              dwe_d = 1'b1;
            DMIU_OP_PROG_WR:
              pmw_d = 1'b1;
            DMIU_OP_PROG_RD, DMIU_OP_PER_RD:
              mrd_d = 1'b1;
            default: ;
          endcase
        end
        if (cnt_q == 8'h01) begin
          st_d = DMIU_ST_WAIT;
        end
      end
      DMIU_ST_WAIT: begin
        // final cycle: register writeback, pointer update
        st_d = DMIU_ST_IDLE;
        busy_d = 1'b0;
        done_d = 1'b1;
        rsel_d = rg_q;
        case (op_q)
          DMIU_OP_SHORT_IMM: begin
            rwe_d = 1'b1;
            // every register kind: value sign-extended into bits 35..16, low zeroed
            rdat_d = acc_load(imm_q);
          end
          DMIU_OP_LONG_IMM: begin
            rwe_d = 1'b1;
            rdat_d = (rg_q == DMIU_RG_ACC_FULL) ? acc_load(imm_q)
                                                : {20'h00000, imm_q};
          end
          DMIU_OP_PROG_RD, DMIU_OP_PER_RD: begin
            rwe_d = 1'b1;
            // whole accumulator extended, single word untouched
            rdat_d = (rg_q == DMIU_RG_ACC_FULL) ?
                     acc_load(i_mem_rdata)
                   : {20'h00000, i_mem_rdata};
          end
          default: ;
        endcase
        if (op_q == DMIU_OP_PROG_RD || op_q == DMIU_OP_PROG_WR)
          pwe_d = 1'b1;
      end
      default: begin
        st_d = DMIU_ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  // registers of the sequencer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= DMIU_ST_IDLE;
      cnt_q <= 8'h00;
      op_q <= DMIU_OP_SHORT_IMM;
      rg_q <= DMIU_RG_OTHER;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      words_q <= 2'h0;
      rwe_q <= 1'b0;
      rsel_q <= DMIU_RG_OTHER;
      rdat_q <= 36'h000000000;
      pwe_q <= 1'b0;
      pdat_q <= 16'h0000;
      dwe_q <= 1'b0;
      pmw_q <= 1'b0;
      mrd_q <= 1'b0;
      addr_q <= 16'h0000;
      wdat_q <= 16'h0000;
      lim_q <= 1'b0;
      ill_q <= 1'b0;
      imm_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      rg_q <= rg_d;
      busy_q <= busy_d;
      done_q <= done_d;
      words_q <= words_d;
      rwe_q <= rwe_d;
      rsel_q <= rsel_d;
      rdat_q <= rdat_d;
      pwe_q <= pwe_d;
      pdat_q <= pdat_d;
      dwe_q <= dwe_d;
      pmw_q <= pmw_d;
      mrd_q <= mrd_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      lim_q <= lim_d;
      ill_q <= ill_d;
      imm_q <= imm_d;
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_words = words_q;
  assign o_reg_we = rwe_q;
  assign o_reg_sel = rsel_q;
  assign o_reg_wdata = rdat_q;
  assign o_ptr_we = pwe_q;
  assign o_ptr_wdata = pdat_q;
  assign o_dmem_we = dwe_q;
  assign o_pmem_we = pmw_q;
  assign o_mem_rd = mrd_q;
  assign o_mem_addr = addr_q;
  assign o_mem_wdata = wdat_q;
  assign o_limit = lim_q;
  assign o_illegal = ill_q;

  // peripheral address always in the top 64 words
  property p_per_addr;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_dmem_we && (op_q == DMIU_OP_PER_WR || op_q == DMIU_OP_PER_IMM))
      |-> (o_mem_addr[15:6] == 10'h3FF);
  endproperty
  a_per_addr: assert property (p_per_addr)
    else $error("peripheral address outside top block");

  // short immediate ends two cycles after issue
  property p_short_time;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_start && !busy_q && i_op == DMIU_OP_SHORT_IMM)
      |-> ##1 !o_done [*3] ##1 o_done;
  endproperty
  a_short_time: assert property (p_short_time)
    else $error("short immediate timing wrong");

  // long immediate ends four cycles after issue
  property p_long_time;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_start && !busy_q && i_op == DMIU_OP_LONG_IMM)
      |-> ##1 !o_done [*5] ##1 o_done;
  endproperty
  a_long_time: assert property (p_long_time)
    else $error("long immediate timing wrong");

  // limit flag never falls
  property p_limit_sticky;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    o_limit |=> o_limit;
  endproperty
  a_limit_sticky: assert property (p_limit_sticky)
    else $error("limit flag dropped");

  // program moves refused while executing from data memory
  property p_refuse;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_start && !busy_q && i_exec_data &&
     (i_op == DMIU_OP_PROG_RD || i_op == DMIU_OP_PROG_WR))
      |=> o_illegal && !o_busy;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("program move not refused");

  // full accumulator load is sign extended with zero low part
  property p_acc_ext;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_reg_we && o_reg_sel == DMIU_RG_ACC_FULL)
      |-> (o_reg_wdata[15:0] == 16'h0000) &&
          (o_reg_wdata[35:32] == {4{o_reg_wdata[31]}});
  endproperty
  a_acc_ext: assert property (p_acc_ext)
    else $error("accumulator load not extended");

  // pointer update comes with the end of a program move
  property p_ptr_upd;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    o_ptr_we |-> o_done && $past(o_busy);
  endproperty
  a_ptr_upd: assert property (p_ptr_upd)
    else $error("pointer update misplaced");

  // saturated word is one of the two limits
  property p_sat_val;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (lim_hit && i_reg == DMIU_RG_ACC_FULL)
      |-> (lim_word == 16'h7FFF || lim_word == 16'h8000);
  endproperty
  a_sat_val: assert property (p_sat_val)
    else $error("saturation value wrong");
endmodule : dmiu_core

// >>> rtl/dmiu_defs.svh
// constants for the data move instruction unit
// Notes on behaviour
// - short immediate -64..63 sign-extended, low zeroed
// - short immediate to register: 2 cycles, 1 word
// - long immediate 16-bit: 4 cycles, 2 words
// - immediate to memory 6 cycles, 2/3 words
// - program move register to/from indirect pointer location
// - post-increment by one or offset; 8+wait cycles
// - pointer updated by one or offset after access
// - full accumulator to 16 bits saturates
// - individual accumulator words never saturate
// - sticky limit flag set on saturation only
// - 16-bit into accumulator: sign-extend, zero low
// - upper word destination writes only that word
// - peripheral address: short address padded with ones
// - peripheral move 2+ea cycles; immediate form 4/2
`ifndef DMIU_DEFS_SVH
`define DMIU_DEFS_SVH
`define DMIU_CYC_SHORT_IMM   8'h02
`define DMIU_CYC_LONG_IMM    8'h04
`define DMIU_CYC_IMM_MEM     8'h06
`define DMIU_CYC_PROG        8'h08
`define DMIU_CYC_PERIPH      8'h02
`define DMIU_CYC_PERIPH_IMM  8'h04
`define DMIU_WRD_ONE         2'h1
`define DMIU_WRD_TWO         2'h2
`define DMIU_WRD_THREE       2'h3
`define DMIU_PERIPH_BASE     10'h3FF
`define DMIU_SAT_POS         16'h7FFF
`define DMIU_SAT_NEG         16'h8000
`define DMIU_LIMIT_BIT       6
`define DMIU_XP_BIT          0
`define DMIU_LC_BITS         13
`endif

// >>> rtl/dmiu_limiter.sv
// saturating source conversion to a 16-bit word
`timescale 1ns/100ps
`include "dmiu_defs.svh"
module dmiu_limiter
  import dmiu_pkg::*;
(
  input  wire logic [35:0] i_acc,      // full accumulator value
  input  wire logic [15:0] i_word,     // plain 16-bit source
  input  wire dmiu_reg_t   i_sel,      // source kind
  output logic      [15:0] o_word,     // value to store
  output logic             o_limited   // saturation applied
);
  logic ext_used;                      // extension holds significance
  // extension in use when bits 35..31 disagree
  always_comb begin
    ext_used = (i_acc[35:31] != 5'h00) && (i_acc[35:31] != 5'h1F);
    o_limited = 1'b0;
    o_word = i_word;
    if (i_sel == DMIU_RG_ACC_FULL) begin
      if (ext_used) begin
        o_limited = 1'b1;
        o_word = i_acc[35] ? `DMIU_SAT_NEG : `DMIU_SAT_POS;
      end else begin
        o_word = i_acc[31:16];
      end
    end else if (i_sel == DMIU_RG_ACC_UPPER) begin
      o_word = i_acc[31:16];
    end else if (i_sel == DMIU_RG_ACC_LOWER) begin
      o_word = i_acc[15:0];
    end
  end
endmodule : dmiu_limiter

// >>> rtl/dmiu_pkg.sv
// types for the data move instruction unit
package dmiu_pkg;
  // operation requested by the decoder
  typedef enum logic [2:0] {
    DMIU_OP_SHORT_IMM = 3'h0,  // 7-bit immediate to register
    DMIU_OP_LONG_IMM  = 3'h1,  // 16-bit immediate to register
    DMIU_OP_IMM_MEM   = 3'h2,  // 16-bit immediate to data memory
    DMIU_OP_PROG_RD   = 3'h3,  // program memory to register
    DMIU_OP_PROG_WR   = 3'h4,  // register to program memory
    DMIU_OP_PER_RD    = 3'h5,  // peripheral word to register
    DMIU_OP_PER_WR    = 3'h6,  // register to peripheral word
    DMIU_OP_PER_IMM   = 3'h7   // immediate to peripheral word
  } dmiu_op_t;
  // register selection of the move
  typedef enum logic [2:0] {
    DMIU_RG_ACC_FULL  = 3'h0,  // full 36-bit accumulator
    DMIU_RG_ACC_UPPER = 3'h1,  // upper accumulator word
    DMIU_RG_ACC_LOWER = 3'h2,  // lower accumulator word
    DMIU_RG_LOOP_CNT  = 3'h3,  // loop_counter
    DMIU_RG_OTHER     = 3'h4   // any other 16-bit register
  } dmiu_reg_t;
  // immediate-to-memory addressing
  typedef enum logic [1:0] {
    DMIU_AM_BASE_OFS  = 2'h0,
    DMIU_AM_STACK_OFS = 2'h1,
    DMIU_AM_ABSOLUTE  = 2'h2
  } dmiu_am_t;
  // sequencer states
  typedef enum logic [1:0] {
    DMIU_ST_IDLE = 2'h0,
    DMIU_ST_BUSY = 2'h1,
    DMIU_ST_WAIT = 2'h2
  } dmiu_state_t;
endpackage : dmiu_pkg

// >>> tb/dmiu_mem_model.sv
// memory partner model: program and data words seen by the move unit
`timescale 1ns/100ps
module dmiu_mem_model (
  input  wire logic        i_core_clk,  // core clock
  input  wire logic        i_rd,        // read strobe from the unit
  input  wire logic        i_wr,        // program or data write strobe
  input  wire logic        i_done,      // end of the move
  input  wire logic [15:0] i_addr,      // word address
  input  wire logic [15:0] i_wdata,     // write word
  output logic      [15:0] o_rdata      // read word
);
  logic [15:0] mem [logic [15:0]];      // sparse word store
  initial o_rdata = 16'h5A5A;
  // read word holds through writeback, then turns over so stale data shows
  always @(posedge i_core_clk) begin
    if (i_wr)
      mem[i_addr] = i_wdata;
    if (i_rd)
      o_rdata <= mem.exists(i_addr) ? mem[i_addr] : 16'hC3C3;
    else if (i_done)
      o_rdata <= ~o_rdata;
  end
endmodule : dmiu_mem_model

// >>> tb/test_data_move_instruction_unit.sv
// self-checking bench for the data move instruction unit
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module test_data_move_instruction_unit
  import dmiu_pkg::*;
;
  logic i_core_clk, i_rst_b, i_start, i_post_ofs, i_exec_data;
  dmiu_op_t    i_op;                 // operation under test
  dmiu_reg_t   i_reg, o_reg_sel;     // register kind in and out
  dmiu_am_t    i_amode;              // immediate-to-memory mode
  logic [6:0]  i_imm7;               // short immediate
  logic [5:0]  i_short_addr;         // peripheral short address
  logic [1:0]  i_ea_cycles, o_words; // extra cycles, words used
  logic [3:0]  i_prog_wait;          // program wait states
  logic [15:0] i_imm16, i_ea_addr, i_pointer, i_offset, i_src;
  logic [15:0] i_mem_rdata, o_ptr_wdata, o_mem_addr, o_mem_wdata;
  logic [35:0] i_acc, o_reg_wdata;   // accumulator in, register out
  logic o_busy, o_done, o_reg_we, o_ptr_we, o_dmem_we, o_pmem_we;
  logic o_mem_rd, o_limit, o_illegal;
  int   fail_count, n_compared, cycle_cnt;
  bit   lim_exp;                     // sticky flag as the model sees it

  dmiu_core dmiu_core_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_start(i_start), .i_op(i_op), .i_reg(i_reg), .i_amode(i_amode),
    .i_imm7(i_imm7), .i_imm16(i_imm16), .i_short_addr(i_short_addr),
    .i_ea_addr(i_ea_addr), .i_ea_cycles(i_ea_cycles),
    .i_post_ofs(i_post_ofs), .i_pointer(i_pointer), .i_offset(i_offset),
    .i_acc(i_acc), .i_src(i_src), .i_prog_wait(i_prog_wait),
    .i_mem_rdata(i_mem_rdata), .i_exec_data(i_exec_data),
    .o_busy(o_busy), .o_done(o_done), .o_words(o_words),
    .o_reg_we(o_reg_we), .o_reg_sel(o_reg_sel), .o_reg_wdata(o_reg_wdata),
    .o_ptr_we(o_ptr_we), .o_ptr_wdata(o_ptr_wdata),
    .o_dmem_we(o_dmem_we), .o_pmem_we(o_pmem_we), .o_mem_rd(o_mem_rd),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .o_limit(o_limit), .o_illegal(o_illegal));

  dmiu_mem_model dmiu_mem_model_i (.i_core_clk(i_core_clk),
    .i_rd(o_mem_rd), .i_wr(o_dmem_we | o_pmem_we), .i_done(o_done),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

  // 40 MHz core clock
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  // prints the counts and the verdict, then stops
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  // hang guard
  always @(posedge i_core_clk) begin
    cycle_cnt++;
    if (cycle_cnt == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  // issues one move with random operands, predicts and checks every result
  task automatic run_op(input dmiu_op_t op, input dmiu_reg_t rg,
                        input dmiu_am_t am, input bit xd, input bit poke,
                        input int edge_v);
    int k;
    int n;
    logic [15:0] w, mw, ma, mv, mad, pv;
    logic [35:0] rv;
    logic [1:0]  wd;
    dmiu_reg_t   rs;
    bit rd, wr, rw, sat, ill, pm, s_rw, s_mw, s_ptr, s_ill;
    @(negedge i_core_clk);
    i_op = op;
    i_reg = rg;
    i_amode = am;
    i_exec_data = xd;
    i_imm7 = (edge_v >= 0) ? 7'(edge_v) : 7'($urandom);
    i_short_addr = (edge_v >= 0) ? 6'(edge_v) : 6'($urandom);
    i_imm16 = 16'($urandom);
    if (rg == DMIU_RG_LOOP_CNT)
      i_imm16[15:13] = 3'h0;
    i_ea_addr = 16'($urandom);
    i_ea_cycles = 2'($urandom % 3);
    i_post_ofs = 1'($urandom);
    i_pointer = 16'($urandom);
    i_offset = 16'($urandom);
    i_prog_wait = 4'($urandom);
    i_acc = {4'($urandom), 32'($urandom)};
    if ($urandom % 2)
      i_acc[35:32] = {4{i_acc[31]}};
    i_src = (rg == DMIU_RG_ACC_UPPER) ? i_acc[31:16] :
            (rg == DMIU_RG_ACC_LOWER) ? i_acc[15:0] : 16'($urandom);
    i_start = 1'b1;
    // expected behaviour from the operation and the driven inputs
    ill = xd && (op == DMIU_OP_PROG_RD || op == DMIU_OP_PROG_WR);
    rd = (op == DMIU_OP_PROG_RD) || (op == DMIU_OP_PER_RD);
    rw = !ill && (rd || op == DMIU_OP_SHORT_IMM || op == DMIU_OP_LONG_IMM);
    wr = !ill && (op inside {DMIU_OP_IMM_MEM, DMIU_OP_PROG_WR,
                             DMIU_OP_PER_WR, DMIU_OP_PER_IMM});
    sat = (i_acc[35:31] != 5'h00) && (i_acc[35:31] != 5'h1F);
    w = i_imm16;
    mw = i_imm16;
    ma = {10'h3FF, i_short_addr};
    n = 4;
    wd = 2'h2;
    if (op == DMIU_OP_SHORT_IMM) begin
      n = 2;
      wd = 2'h1;
    end else if (op == DMIU_OP_IMM_MEM) begin
      n = 6;
      wd = (am == DMIU_AM_ABSOLUTE) ? 2'h3 : 2'h2;
      ma = i_ea_addr;
    end else if (op == DMIU_OP_PROG_RD || op == DMIU_OP_PROG_WR) begin
      // a refused move ends at the take edge itself
      n = ill ? -1 : 8 + i_prog_wait;
      wd = 2'h1;
      ma = i_pointer;
    end else if (op == DMIU_OP_PER_RD || op == DMIU_OP_PER_WR) begin
      n = 2 + i_ea_cycles;
      wd = 2'h1 + i_ea_cycles;
    end
    if (rd) begin
      w = 16'($urandom);
      dmiu_mem_model_i.mem[ma] = w;
    end
    if (op == DMIU_OP_PROG_WR || op == DMIU_OP_PER_WR) begin
      mw = (rg != DMIU_RG_ACC_FULL) ? i_src : !sat ? i_acc[31:16] :
           i_acc[35] ? 16'h8000 : 16'h7FFF;
      if (wr && rg == DMIU_RG_ACC_FULL && sat)
        lim_exp = 1'b1;
    end
    // watch the ports cycle by cycle until the end pulse
    for (k = 0; k < 40; k++) begin
      @(negedge i_core_clk);
      i_start = poke && (k == 1);
      if (o_reg_we) begin
        s_rw = 1'b1;
        rv = o_reg_wdata;
        rs = o_reg_sel;
      end
      if (o_dmem_we || o_pmem_we) begin
        s_mw = 1'b1;
        mv = o_mem_wdata;
        mad = o_mem_addr;
        pm = o_pmem_we;
      end
      if (o_mem_rd)
        mad = o_mem_addr;
      if (o_ptr_we) begin
        s_ptr = 1'b1;
        pv = o_ptr_wdata;
      end
      if (o_illegal)
        s_ill = 1'b1;
      if (o_done)
        break;
    end
    `CHK(k, n + 1)
    `CHK(o_words, wd)
    `CHK(s_rw, rw)
    if (rw && op == DMIU_OP_SHORT_IMM)
      `CHK(rv, {{13{i_imm7[6]}}, i_imm7, 16'h0000})
    else if (rw && rg == DMIU_RG_ACC_FULL)
      `CHK(rv, {{4{w[15]}}, w, 16'h0000})
    else if (rw)
      `CHK(rv[15:0], w)
    if (rw)
      `CHK(rs, rg)
    `CHK(s_mw, wr)
    if (wr)
      `CHK({pm, mv}, {op == DMIU_OP_PROG_WR, mw})
    if (!ill && (wr || rd))
      `CHK(mad, ma)
    if (op == DMIU_OP_PROG_RD || op == DMIU_OP_PROG_WR)
      `CHK(s_ptr, !ill)
    if (s_ptr)
      `CHK(pv, 16'(i_pointer + (i_post_ofs ? i_offset : 16'h1)))
    `CHK(s_ill, ill)
    `CHK(o_limit, lim_exp)
    @(negedge i_core_clk);
    i_start = 1'b0;
    `CHK({o_busy, o_done}, 2'h0)
  endtask : run_op

  // main sequence
  initial begin
    fail_count = 0;
    n_compared = 0;
    cycle_cnt = 0;
    lim_exp = 1'b0;
    i_rst_b = 1'b0;
    i_start = 1'b0;
    i_op = DMIU_OP_SHORT_IMM;
    i_reg = DMIU_RG_ACC_FULL;
    i_amode = DMIU_AM_BASE_OFS;
    {i_imm7, i_short_addr, i_ea_cycles, i_prog_wait} = 19'h0;
    {i_imm16, i_ea_addr, i_pointer, i_offset, i_src} = 80'h0;
    {i_post_ofs, i_exec_data} = 2'h0;
    i_acc = 36'h0;
    void'($urandom(34825));
    repeat (3) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    `CHK({o_busy, o_done, o_limit}, 3'h0)
    // immediates into every register kind, both range ends
    for (int r = 0; r < 5; r++) begin
      run_op(DMIU_OP_SHORT_IMM, dmiu_reg_t'(r), DMIU_AM_BASE_OFS, 0, 0, 'h40);
      run_op(DMIU_OP_SHORT_IMM, dmiu_reg_t'(r), DMIU_AM_BASE_OFS, 0, 1, 'h3F);
      run_op(DMIU_OP_LONG_IMM, dmiu_reg_t'(r), DMIU_AM_BASE_OFS, 0, 0, -1);
    end
    for (int a = 0; a < 3; a++)
      run_op(DMIU_OP_IMM_MEM, DMIU_RG_OTHER, dmiu_am_t'(a), 0, a == 1, -1);
    // program and peripheral traffic with random register kinds
    for (int i = 0; i < 40; i++) begin
      for (int o = 3; o < 7; o++)
        run_op(dmiu_op_t'(o), dmiu_reg_t'($urandom % 5), DMIU_AM_BASE_OFS,
               0, i == 0, (i < 2) ? 'h40 - i : -1);
    end
    run_op(DMIU_OP_PER_IMM, DMIU_RG_OTHER, DMIU_AM_BASE_OFS, 0, 0, 'h40);
    run_op(DMIU_OP_PER_IMM, DMIU_RG_OTHER, DMIU_AM_BASE_OFS, 0, 1, 'h3F);
    // program moves while executing from data memory are refused
    run_op(DMIU_OP_PROG_RD, DMIU_RG_ACC_FULL, DMIU_AM_BASE_OFS, 1, 0, -1);
    run_op(DMIU_OP_PROG_WR, DMIU_RG_ACC_FULL, DMIU_AM_BASE_OFS, 1, 0, -1);
    give_verdict();
  end
endmodule : test_data_move_instruction_unit
